//--- src/arb_pkg.sv
// Package: constants and carrier types of the result threshold bank
package arb_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ARB_DW = 24;
   localparam int ARB_AW = 8;
   localparam int ARB_NLIM = 5;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ARB_OFS_R4_LOWER = 8'h24;
   localparam logic [7:0] ARB_OFS_R5_LOWER = 8'h25;
   localparam logic [7:0] ARB_OFS_R6_LOWER = 8'h26;
   localparam logic [7:0] ARB_OFS_R7_LOWER = 8'h27;
   localparam logic [7:0] ARB_OFS_R0_UPPER = 8'h28;

   // ----------------------------------------------------------------
   // Field layout, reset and read values
   // ----------------------------------------------------------------
   localparam int ARB_LIMIT_MSB = 23;
   localparam int ARB_LIMIT_LSB = 0;
   localparam logic [23:0] ARB_LIMIT_RST = 24'h000000;
   localparam logic [23:0] ARB_UNMAPPED_RD = 24'h000000;

   // Slot index of each limit inside the bank
   localparam int ARB_SLOT_R4 = 0;
   localparam int ARB_SLOT_R5 = 1;
   localparam int ARB_SLOT_R6 = 2;
   localparam int ARB_SLOT_R7 = 3;
   localparam int ARB_SLOT_R0 = 4;

   // Number-format setting codes
   typedef enum logic {
      ARB_FMT_TWOS = 1'b0,
      ARB_FMT_OFFSET = 1'b1
   } arb_fmt_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [23:0] wdata;
   } arb_req_t;

   typedef struct packed {
      logic valid;
      logic [23:0] rdata;
   } arb_rsp_t;

   typedef struct packed {
      logic [23:0] result0;
      logic [23:0] result4;
      logic [23:0] result5;
      logic [23:0] result6;
      logic [23:0] result7;
   } arb_results_t;

   typedef struct packed {
      logic over_range_flag_0;
      logic under_range_flag_7;
      logic under_range_flag_6;
      logic under_range_flag_5;
      logic under_range_flag_4;
   } arb_flags_t;

endpackage

//--- src/arb_threshold_bank.sv
// Module: limit registers and range comparators for stored results
`timescale 1ns/10ps

module arb_threshold_bank
   import arb_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Register access from the serial control port
   input wire arb_req_t req,
   output arb_rsp_t rsp,
   // Stored conversion results and coding settings
   input wire arb_results_t results,
   input wire logic polarity_select,
   input wire arb_fmt_t number_format,
   // Range status
   output arb_flags_t flags
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic [ARB_NLIM-1:0] slot_hit;
   logic [2:0] wr_slot;
   logic wr_hit;
   logic take_wr;
   logic take_rd;

   // One-hot slot select plus an index for the single write port
   always_comb begin
      slot_hit = '0;
      wr_slot = 3'h0;
      unique case (req.addr)
         ARB_OFS_R4_LOWER: begin
            slot_hit[ARB_SLOT_R4] = 1'b1;
            wr_slot = 3'(ARB_SLOT_R4);
         end
         ARB_OFS_R5_LOWER: begin
            slot_hit[ARB_SLOT_R5] = 1'b1;
            wr_slot = 3'(ARB_SLOT_R5);
         end
         ARB_OFS_R6_LOWER: begin
            slot_hit[ARB_SLOT_R6] = 1'b1;
            wr_slot = 3'(ARB_SLOT_R6);
         end
         ARB_OFS_R7_LOWER: begin
            slot_hit[ARB_SLOT_R7] = 1'b1;
            wr_slot = 3'(ARB_SLOT_R7);
         end
         ARB_OFS_R0_UPPER: begin
            slot_hit[ARB_SLOT_R0] = 1'b1;
            wr_slot = 3'(ARB_SLOT_R0);
         end
         default: begin
            // Unmapped offsets select nothing
            slot_hit = '0;
            wr_slot = 3'h0;
         end
      endcase
   end

   assign wr_hit = |slot_hit;
   assign take_wr = ce && req.wr && wr_hit;
   assign take_rd = ce && req.rd;

   // ----------------------------------------------------------------
   // Limit storage
   // ----------------------------------------------------------------
   logic [ARB_DW-1:0] limit [ARB_NLIM];

   // Whole field written at once; no partial lanes on this port
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < ARB_NLIM; i++) begin
            limit[i] <= ARB_LIMIT_RST;
         end
      end else if (take_wr) begin
         limit[wr_slot] <= req.wdata[ARB_LIMIT_MSB:ARB_LIMIT_LSB];
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [ARB_DW-1:0] next_rdata;

   // Plain mux of stored values, so reading disturbs nothing
   always_comb begin
      next_rdata = ARB_UNMAPPED_RD;
      for (int i = 0; i < ARB_NLIM; i++) begin
         if (slot_hit[i]) begin
            next_rdata = limit[i];
         end
      end
   end

   // Valid is high for one enabled cycle after each taken read; it holds its value while ce is low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsp.valid <= 1'b0;
      end else if (ce) begin
         rsp.valid <= req.rd;
      end
   end

   // Data holds until the next taken read; a write in the same cycle
   // is not yet visible, so the old value is returned
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rsp.rdata <= '0;
      end else if (take_rd) begin
         rsp.rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Comparators
   // ----------------------------------------------------------------
   // Signed order only for bipolar two's complement; offset binary and
   // unipolar codes already sort as unsigned. Limits are not recoded on a
   // setting change, which is why the host must rewrite them.
   logic signed_cmp;
   assign signed_cmp = polarity_select && (number_format == ARB_FMT_TWOS);

   function automatic logic below(input logic [23:0] a, input logic [23:0] b,
                                  input logic sgn);
      below = sgn ? ($signed(a) < $signed(b)) : (a < b);
   endfunction

   logic [ARB_DW-1:0] cmp_lhs [ARB_NLIM];
   logic [ARB_DW-1:0] cmp_rhs [ARB_NLIM];
   logic [ARB_NLIM-1:0] cmp_out;

   // Operand routing; the upper limit swaps sides so one strict
   // less-than serves both directions
   always_comb begin
      cmp_lhs[ARB_SLOT_R4] = results.result4;
      cmp_rhs[ARB_SLOT_R4] = limit[ARB_SLOT_R4];
      cmp_lhs[ARB_SLOT_R5] = results.result5;
      cmp_rhs[ARB_SLOT_R5] = limit[ARB_SLOT_R5];
      cmp_lhs[ARB_SLOT_R6] = results.result6;
      cmp_rhs[ARB_SLOT_R6] = limit[ARB_SLOT_R6];
      cmp_lhs[ARB_SLOT_R7] = results.result7;
      cmp_rhs[ARB_SLOT_R7] = limit[ARB_SLOT_R7];
      cmp_lhs[ARB_SLOT_R0] = limit[ARB_SLOT_R0];
      cmp_rhs[ARB_SLOT_R0] = results.result0;
   end

   for (genvar g = 0; g < ARB_NLIM; g++) begin : g_cmp
      assign cmp_out[g] = below(cmp_lhs[g], cmp_rhs[g], signed_cmp);
   end

   // ----------------------------------------------------------------
   // Range status
   // ----------------------------------------------------------------
   arb_flags_t next_flags;

   always_comb begin
      next_flags.under_range_flag_4 = cmp_out[ARB_SLOT_R4];
      next_flags.under_range_flag_5 = cmp_out[ARB_SLOT_R5];
      next_flags.under_range_flag_6 = cmp_out[ARB_SLOT_R6];
      next_flags.under_range_flag_7 = cmp_out[ARB_SLOT_R7];
      next_flags.over_range_flag_0 = cmp_out[ARB_SLOT_R0];
   end

   // Live levels, not sticky: each enabled edge recomputes them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags <= '0;
      end else if (ce) begin
         flags <= next_flags;
      end
   end

endmodule // arb_threshold_bank

//--- testbench/arb_host.sv
// Host model issuing register requests to the bank
`timescale 1ns/10ps
module arb_host import arb_pkg::*; (
   input wire logic clk,
   output arb_req_t req
);
   initial req = '0;
   task automatic xfer(input logic w, input logic [7:0] a, input logic [23:0] d);
      @(negedge clk) req <= {w, !w, a, d};
      @(negedge clk) req <= {2'b00, ~a, ~d}; // Released lines never echo old data
   endtask
endmodule // arb_host

//--- testbench/arb_threshold_bank_chk.sv
// Checker for the threshold bank ports
`timescale 1ns/10ps
module arb_chk import arb_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire arb_req_t req,
   input wire arb_rsp_t rsp,
   input wire arb_results_t results,
   input wire logic polarity_select,
   input wire arb_fmt_t number_format,
   input wire arb_flags_t flags
);
   logic [23:0] lim [5];
   wire m = req.addr inside {[8'h24:8'h28]};
   wire [23:0] rv = lim[3'(req.addr - 8'h24)];
   // Sign flip turns the signed compare into an unsigned one
   wire [23:0] k = {polarity_select && number_format == ARB_FMT_TWOS, 23'h0};
   wire [4:0] e = {(lim[4]^k) < (results.result0^k), (results.result7^k) < (lim[3]^k),
      (results.result6^k) < (lim[2]^k), (results.result5^k) < (lim[1]^k),
      (results.result4^k) < (lim[0]^k)};
   always_ff @(posedge clk or posedge rst)
      if (rst) lim <= '{default: 24'h000000};
      else if (ce && req.wr && m) lim[3'(req.addr - 8'h24)] <= req.wdata;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_u4: assert property (ce |=> flags[0] == $past(e[0])) else $error("flag u4");
   a_u5: assert property (ce |=> flags[1] == $past(e[1])) else $error("flag u5");
   a_u6: assert property (ce |=> flags[2] == $past(e[2])) else $error("flag u6");
   a_u7: assert property (ce |=> flags[3] == $past(e[3])) else $error("flag u7");
   a_o0: assert property (ce |=> flags[4] == $past(e[4])) else $error("flag o0");
   a_sgn: assert property (ce && k[23] |=> flags == $past(e)) else $error("signed");
   a_vld: assert property (ce && req.rd |=> rsp.valid) else $error("valid");
   a_rd: assert property (ce && req.rd && m |=> rsp.rdata == $past(rv)) else $error("rd");
endmodule // arb_chk

//--- testbench/arb_threshold_bank_tb.sv
// Bench for the threshold bank
`timescale 1ns/10ps
module arb_threshold_bank_tb import arb_pkg::*; ;
   logic clk = 0, rst = 1, pol = 0, ce = 1;
   arb_rsp_t rsp;
   arb_flags_t flags;
   arb_fmt_t fmt = ARB_FMT_OFFSET;
   arb_results_t res = '0;
   arb_req_t req;
   logic [23:0] q[$], v;
   int num_errors = 0, num_checks = 0, seed = 89;
   arb_host H (.clk(clk), .req(req));
   arb_threshold_bank DUT (.clk(clk), .rst(rst), .ce(ce), .req(req), .rsp(rsp),
      .results(res), .polarity_select(pol), .number_format(fmt), .flags(flags));
   initial forever #20 clk = ~clk;
   task automatic chk(input logic [23:0] s, input logic [23:0] e, input string n);
      num_checks++;
      if (s !== e) $display("Error %s expected %h seen %h", n, e, s);
      if (s !== e) num_errors++;
   endtask
   task automatic stop_test(input int late);
      num_errors += late;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(negedge clk)
      if (rsp.valid === 1'b1) chk(rsp.rdata, q.pop_front(), "rdata");
   initial #20000 stop_test(1);
   initial begin
      #400 rst = 0;
      // Last offset is unmapped: write ignored, read gives zero
      for (int i = 0; i < 6; i++) begin
         v = 24'($random(seed));
         H.xfer(1, 8'h24 + 8'(i), v);
         q.push_back(i < 5 ? v : 24'h000000);
         H.xfer(0, 8'h24 + 8'(i), ~v);
      end
      $display("register access done");
      for (int i = 0; i < 5; i++) H.xfer(1, 8'h24 + 8'(i), 24'h800000);
      res = {24'h800001, 24'h7FFFFF, 24'h800000, 24'h7FFFFF, 24'h800000};
      for (int i = 0; i < 4; i++) begin
         pol = i[1];
         fmt = arb_fmt_t'(i[0]);
         repeat (2) @(negedge clk);
         chk(24'(flags), pol && !fmt ? 24'h10 : 24'h15, "flags");
      end
      $display("flag checks done");
      // Write with the enable low must not land
      ce = 0;
      H.xfer(1, 8'h24, 24'h123456);
      ce = 1;
      q.push_back(24'h800000);
      H.xfer(0, 8'h24, 24'h000000);
      $display("freeze check done");
      repeat (3) @(negedge clk);
      stop_test(0);
   end
endmodule // arb_threshold_bank_tb
bind arb_threshold_bank arb_chk u_chk (.*);
